/* core/pixel_port_mux_color_mapper.sv */
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
// Behaviour
// - Code 1110 uses each 8-bit channel directly as its table index.
// - Resolution bit one gives 10-bit entries, 30 bits; zero gives 8-bit, 24 bits.
// - Code 1011 maps 16 bits to 5/6/5 low index bits, 64 locations.
// - Codes 1100 and 1101 map 15 bits to 5 low index bits each.
// - Codes 0000, 0100, 1000 index a full entry with one 8-bit pixel.
// - 16-bit mode reads only red and green inputs, locations 0 to 63.
// - First 15-bit mode takes the top five bits of red, green, blue.
// - Second 15-bit mode reads only red and green, locations 0 to 31.
// - 24-bit bypass skips mask and table; channel fills DAC top, low bits zero.
// - Bypass comes from the mode field or per pixel from palette select.
// - 16-bit bypass puts red/green bits on 5/6/5 DAC top bits.
// - 15-bit bypass puts 7 red, 8 green bits on five DAC top bits.
// - One pixel per clock, cycling A to D in 4:1, A and B in 2:1.
// - The 8:1 rate is only used with 8-bit pseudo colour.
// - Blank, sync, parity, tri-level sync change only on group boundaries.
// - Every pixel port input is captured on the latch strobe rising edge.
// - Mux code 10 forces pseudo colour and latch output at clock over eight.
// - 8:1 order is green then red for pixels A, B, C, D.
// - In 8:1 the blue inputs give extra palette select bits per pixel.
// - Latch output runs at clock over 8, 4 or 2 with the rate.
// - After reset the sequence starts at pixel A.
// - Writing one, zero, one to the sequence bit restarts at pixel A.
module pixel_port_mux_color_mapper #(
  parameter logic [1:0] PSEUDO_CH_0    = pixmux_pkg::CH_GREEN,
  parameter logic [1:0] PSEUDO_CH_4    = pixmux_pkg::CH_RED,
  parameter logic [1:0] PSEUDO_CH_8    = pixmux_pkg::CH_BLUE,
  parameter bit         PACK_SWAP      = 1'b0,
  parameter bit         PS_BYPASS_EN   = 1'b1,
  parameter logic [1:0] PS_BYPASS_CODE = 2'h3
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  // Register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  // Pixel port pins, port A in the low byte
  input  wire logic [31:0] red_pixel_input_i,
  input  wire logic [31:0] green_pixel_input_i,
  input  wire logic [31:0] blue_pixel_input_i,
  input  wire logic [7:0]  palette_select_inputs_i,
  input  wire logic        pixel_latch_strobe_i,
  input  wire logic        blank_n_i,
  input  wire logic        sync_n_i,
  input  wire logic        odd_even_i,
  input  wire logic        tri_level_sync_i,
  // Strobe to the frame buffer
  output logic             latch_strobe_out_o,
  // Table lookup or DAC words, one pixel per clock
  output logic             lut_lookup_o,
  output logic             lut_wide_o,
  output logic [7:0]       lut_idx_red_o,
  output logic [7:0]       lut_idx_green_o,
  output logic [7:0]       lut_idx_blue_o,
  output logic [9:0]       dac_red_o,
  output logic [9:0]       dac_green_o,
  output logic [9:0]       dac_blue_o,
  output logic [1:0]       palette_select_o,
  // Video controls, held per group
  output logic             blank_n_o,
  output logic             sync_n_o,
  output logic             odd_even_o,
  output logic             tri_level_sync_o
);

  localparam int GW   = pixmux_pkg::PORTS * pixmux_pkg::PIX_W;
  localparam int IN_W = 3 * GW + 8 + 4 + 1;

  if (PSEUDO_CH_0 > pixmux_pkg::CH_BLUE || PSEUDO_CH_4 > pixmux_pkg::CH_BLUE ||
      PSEUDO_CH_8 > pixmux_pkg::CH_BLUE) begin : g_bad_channel
    $error("pseudo colour channel parameter out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and group latch

  logic [IN_W-1:0] in_raw;
  logic [IN_W-1:0] in_s1;
  logic [IN_W-1:0] in_s2;
  logic            strobe_d;
  logic            strobe_edge;
  logic [IN_W-2:0] lat;
  logic [IN_W-2:0] act;

  assign in_raw = {pixel_latch_strobe_i, blank_n_i, sync_n_i, odd_even_i,
                   tri_level_sync_i, palette_select_inputs_i,
                   blue_pixel_input_i, green_pixel_input_i, red_pixel_input_i};

  // Data and strobe share the same two-stage path, so setup at the pins
  // carries over to the capture below
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      in_s1    <= '0;
      in_s2    <= '0;
      strobe_d <= 1'b0;
    end else begin
      in_s1    <= in_raw;
      in_s2    <= in_s1;
      strobe_d <= in_s2[IN_W-1];
    end
  end

  // The strobe only needs to be a whole division of the clock
  assign strobe_edge = in_s2[IN_W-1] & ~strobe_d;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      lat <= '0;
    end else if (strobe_edge) begin
      lat <= in_s2[IN_W-2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]  ctrl;
  logic [7:0]  mask;
  logic [1:0]  seq_hist;
  logic        wr_ctrl;
  logic        restart;
  logic [2:0]  cnt;
  logic [2:0]  next_cnt;
  logic [2:0]  last;
  logic [1:0]  mux_sel;
  logic        eight;
  pixmux_pkg::pix_mode_e eff_mode;

  assign wr_ctrl = reg_wr_i && (reg_addr_i == pixmux_pkg::ADDR_CTRL);
  assign restart = wr_ctrl && reg_wdata_i[pixmux_pkg::CTRL_SEQ_BIT] &&
                   (seq_hist == 2'h2);

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      ctrl <= pixmux_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= reg_wdata_i[7:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      mask <= pixmux_pkg::MASK_RESET;
    end else if (reg_wr_i && reg_addr_i == pixmux_pkg::ADDR_MASK) begin
      mask <= reg_wdata_i[7:0];
    end
  end

  // Last two values written to the sequence bit
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      seq_hist <= 2'h0;
    end else if (wr_ctrl) begin
      seq_hist <= {seq_hist[0], reg_wdata_i[pixmux_pkg::CTRL_SEQ_BIT]};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      reg_rdata_o <= pixmux_pkg::RDATA_IDLE;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        pixmux_pkg::ADDR_CTRL:   reg_rdata_o <= {24'h0, ctrl};
        pixmux_pkg::ADDR_MASK:   reg_rdata_o <= {24'h0, mask};
        pixmux_pkg::ADDR_STATUS: reg_rdata_o <= {25'h0, eff_mode, 1'b0, cnt};
        default:                 reg_rdata_o <= pixmux_pkg::RDATA_IDLE;
      endcase
    end else begin
      reg_rdata_o <= pixmux_pkg::RDATA_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase counter and strobe output

  assign mux_sel = {ctrl[pixmux_pkg::CTRL_MUX_HI], ctrl[pixmux_pkg::CTRL_MUX_LO]};
  assign eight   = (mux_sel == pixmux_pkg::MUX_8TO1);

  always_comb begin
    case (mux_sel)
      pixmux_pkg::MUX_8TO1: last = pixmux_pkg::LAST_8;
      pixmux_pkg::MUX_2TO1: last = pixmux_pkg::LAST_2;
      default:              last = pixmux_pkg::LAST_4;
    endcase
  end

  // A rate change mid-group wraps at once rather than overrunning the group
  always_comb begin
    if (restart || cnt >= last) begin
      next_cnt = 3'h0;
    end else begin
      next_cnt = cnt + 3'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      cnt <= 3'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      latch_strobe_out_o <= 1'b1;
    end else begin
      latch_strobe_out_o <= (next_cnt <= (last >> 1));
    end
  end

  // Controls only move at the group boundary, pixels are double buffered
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      act <= '0;
    end else if (cnt >= last) begin
      act <= lat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel pick and mode decode

  logic [GW-1:0] act_red;
  logic [GW-1:0] act_green;
  logic [GW-1:0] act_blue;
  logic [7:0]    act_ps;
  logic [1:0]    port;
  logic [7:0]    pr;
  logic [7:0]    pg;
  logic [7:0]    pb;
  logic [1:0]    ps;
  logic [1:0]    pch;
  logic [15:0]   w16;
  logic [14:0]   w15;

  assign act_red   = act[GW-1:0];
  assign act_green = act[2*GW-1:GW];
  assign act_blue  = act[3*GW-1:2*GW];
  assign act_ps    = act[3*GW+7:3*GW];
  assign port      = eight ? cnt[2:1] : cnt[1:0];
  assign pr        = act_red[{port, 3'h0} +: 8];
  assign pg        = act_green[{port, 3'h0} +: 8];
  assign pb        = act_blue[{port, 3'h0} +: 8];
  // Red slots of 8:1 take their select bits from the blue port A pins
  assign ps = (eight && cnt[0]) ? act_blue[{port, 1'b0} +: 2]
                                : act_ps[{port, 1'b0} +: 2];
  // Assumed packing: red in the upper byte unless swapped
  assign w16 = PACK_SWAP ? {pg, pr} : {pr, pg};
  assign w15 = PACK_SWAP ? {pg[6:0], pr} : {pr[6:0], pg};

  always_comb begin
    pch = pixmux_pkg::CH_GREEN;
    if (eight) begin
      eff_mode = pixmux_pkg::MODE_PSEUDO;
      pch      = cnt[0] ? pixmux_pkg::CH_RED : pixmux_pkg::CH_GREEN;
    end else begin
      case (ctrl[pixmux_pkg::CTRL_MODE_LSB +: 4])
        pixmux_pkg::CM_TRUE24:  eff_mode = pixmux_pkg::MODE_TRUE24;
        pixmux_pkg::CM_TRUE16:  eff_mode = pixmux_pkg::MODE_TRUE16;
        pixmux_pkg::CM_TRUE15A: eff_mode = pixmux_pkg::MODE_TRUE15A;
        pixmux_pkg::CM_TRUE15B: eff_mode = pixmux_pkg::MODE_TRUE15B;
        pixmux_pkg::CM_BYP24:   eff_mode = pixmux_pkg::MODE_BYP24;
        pixmux_pkg::CM_BYP16:   eff_mode = pixmux_pkg::MODE_BYP16;
        pixmux_pkg::CM_BYP15:   eff_mode = pixmux_pkg::MODE_BYP15;
        pixmux_pkg::CM_PSEUDO0: begin
          eff_mode = pixmux_pkg::MODE_PSEUDO;
          pch      = PSEUDO_CH_0;
        end
        pixmux_pkg::CM_PSEUDO4: begin
          eff_mode = pixmux_pkg::MODE_PSEUDO;
          pch      = PSEUDO_CH_4;
        end
        pixmux_pkg::CM_PSEUDO8: begin
          eff_mode = pixmux_pkg::MODE_PSEUDO;
          pch      = PSEUDO_CH_8;
        end
        default: eff_mode = pixmux_pkg::MODE_PSEUDO;
      endcase
    end
  end

  // Per-pixel bypass keeps the 16- or 15-bit data width of the programmed mode; every other mode bypasses at 24 bits
  pixmux_pkg::pix_mode_e pix_mode;

  always_comb begin
    pix_mode = eff_mode;
    if (PS_BYPASS_EN && !eight && ps == PS_BYPASS_CODE) begin
      case (eff_mode)
        pixmux_pkg::MODE_TRUE16, pixmux_pkg::MODE_BYP16:
          pix_mode = pixmux_pkg::MODE_BYP16;
        pixmux_pkg::MODE_TRUE15A, pixmux_pkg::MODE_TRUE15B, pixmux_pkg::MODE_BYP15:
          pix_mode = pixmux_pkg::MODE_BYP15;
        default: pix_mode = pixmux_pkg::MODE_BYP24;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Colour mapping

  logic       next_look;
  logic [7:0] next_ir;
  logic [7:0] next_ig;
  logic [7:0] next_ib;
  logic [9:0] next_dr;
  logic [9:0] next_dg;
  logic [9:0] next_db;
  logic [7:0] px;

  always_comb begin
    next_look = 1'b1;
    next_ir   = 8'h00;
    next_ig   = 8'h00;
    next_ib   = 8'h00;
    next_dr   = 10'h000;
    next_dg   = 10'h000;
    next_db   = 10'h000;
    case (pch)
      pixmux_pkg::CH_RED:  px = pr;
      pixmux_pkg::CH_BLUE: px = pb;
      default:             px = pg;
    endcase
    case (pix_mode)
      pixmux_pkg::MODE_TRUE24: begin
        next_ir = pr;
        next_ig = pg;
        next_ib = pb;
      end
      pixmux_pkg::MODE_TRUE16: begin
        next_ir = {3'h0, w16[15:11]};
        next_ig = {2'h0, w16[10:5]};
        next_ib = {3'h0, w16[4:0]};
      end
      pixmux_pkg::MODE_TRUE15A: begin
        next_ir = {3'h0, pr[7:3]};
        next_ig = {3'h0, pg[7:3]};
        next_ib = {3'h0, pb[7:3]};
      end
      pixmux_pkg::MODE_TRUE15B: begin
        next_ir = {3'h0, w15[14:10]};
        next_ig = {3'h0, w15[9:5]};
        next_ib = {3'h0, w15[4:0]};
      end
      pixmux_pkg::MODE_BYP24: begin
        next_look = 1'b0;
        next_dr   = {pr, 2'h0};
        next_dg   = {pg, 2'h0};
        next_db   = {pb, 2'h0};
      end
      pixmux_pkg::MODE_BYP16: begin
        next_look = 1'b0;
        next_dr   = {w16[15:11], 5'h00};
        next_dg   = {w16[10:5], 4'h0};
        next_db   = {w16[4:0], 5'h00};
      end
      pixmux_pkg::MODE_BYP15: begin
        next_look = 1'b0;
        next_dr   = {w15[14:10], 5'h00};
        next_dg   = {w15[9:5], 5'h00};
        next_db   = {w15[4:0], 5'h00};
      end
      default: begin
        next_ir = px & mask;
        next_ig = px & mask;
        next_ib = px & mask;
      end
    endcase
  end

  pixmux_pkg::pix_mode_e out_mode;

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      lut_lookup_o     <= 1'b1;
      lut_idx_red_o    <= 8'h00;
      lut_idx_green_o  <= 8'h00;
      lut_idx_blue_o   <= 8'h00;
      dac_red_o        <= 10'h000;
      dac_green_o      <= 10'h000;
      dac_blue_o       <= 10'h000;
      palette_select_o <= 2'h0;
      out_mode         <= pixmux_pkg::MODE_PSEUDO;
    end else begin
      lut_lookup_o     <= next_look;
      lut_idx_red_o    <= next_ir;
      lut_idx_green_o  <= next_ig;
      lut_idx_blue_o   <= next_ib;
      dac_red_o        <= next_dr;
      dac_green_o      <= next_dg;
      dac_blue_o       <= next_db;
      palette_select_o <= ps;
      out_mode         <= pix_mode;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      blank_n_o        <= 1'b0;
      sync_n_o         <= 1'b1;
      odd_even_o       <= 1'b0;
      tri_level_sync_o <= 1'b0;
    end else begin
      {blank_n_o, sync_n_o, odd_even_o, tri_level_sync_o} <= act[3*GW+11:3*GW+8];
    end
  end

  // Table entry width follows the resolution bit
  assign lut_wide_o = ctrl[pixmux_pkg::CTRL_RES_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  sequence s_seq_restart;
    wr_ctrl && reg_wdata_i[pixmux_pkg::CTRL_SEQ_BIT] && seq_hist == 2'h2;
  endsequence

  sequence s_eight_steady;
    eight && !restart ##1 eight;
  endsequence

  a_restart_phase: assert property (s_seq_restart |=> cnt == 3'h0 && latch_strobe_out_o)
    else $error("sequence restart did not return to pixel A");

  a_group_wrap: assert property (cnt == last && !restart && $stable(mux_sel) |=> cnt == 3'h0)
    else $error("phase did not wrap at the end of a group");

  a_strobe_eighth: assert property (eight && cnt == 3'h4 |-> !latch_strobe_out_o)
    else $error("latch strobe high in second half of 8:1 group");

  a_force_pseudo: assert property (eight |-> eff_mode == pixmux_pkg::MODE_PSEUDO)
    else $error("8:1 rate without pseudo colour");

  a_order_green: assert property (eight && cnt == 3'h0 ##1 eight && cnt == 3'h1 |->
                                  lut_idx_green_o == (act_green[7:0] & mask))
    else $error("8:1 first slot is not green A");

  a_order_red: assert property (s_eight_steady ##0 cnt == 3'h2 |->
                                lut_idx_red_o == (act_red[7:0] & mask))
    else $error("8:1 second slot is not red A");

  a_ctl_boundary: assert property ($changed(blank_n_o) && !$past(restart, 2) |->
                                   $past(cnt, 2) >= $past(last, 2))
    else $error("blank changed inside a latch group");

  a_latch_capture: assert property (strobe_edge |=> lat == $past(in_s2[IN_W-2:0]))
    else $error("pixel port not captured on latch strobe edge");

  a_bypass_lsbs: assert property (out_mode == pixmux_pkg::MODE_BYP24 |->
                                  !lut_lookup_o && dac_red_o[1:0] == 2'h0 &&
                                  dac_blue_o[1:0] == 2'h0)
    else $error("24-bit bypass word has nonzero low bits");

  a_true24_direct: assert property ($past(pix_mode) == pixmux_pkg::MODE_TRUE24 |->
                                    lut_lookup_o && lut_idx_green_o == $past(pg))
    else $error("24-bit true colour index differs from channel");

endmodule

/* core/pixmux_pkg.sv */
package pixmux_pkg;

  // Register byte addresses
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_MASK   = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RES_BIT  = 4;
  localparam int CTRL_MUX_LO   = 5;
  localparam int CTRL_MUX_HI   = 6;
  localparam int CTRL_SEQ_BIT  = 7;

  // Values after reset
  localparam logic [7:0]  CTRL_RESET = 8'hff;
  localparam logic [7:0]  MASK_RESET = 8'hff;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

  // Colour mode field codes
  localparam logic [3:0] CM_TRUE24  = 4'he;
  localparam logic [3:0] CM_TRUE16  = 4'hb;
  localparam logic [3:0] CM_TRUE15A = 4'hc;
  localparam logic [3:0] CM_TRUE15B = 4'hd;
  localparam logic [3:0] CM_PSEUDO0 = 4'h0;
  localparam logic [3:0] CM_PSEUDO4 = 4'h4;
  localparam logic [3:0] CM_PSEUDO8 = 4'h8;
  localparam logic [3:0] CM_BYP24   = 4'h1;
  localparam logic [3:0] CM_BYP16   = 4'h2;
  localparam logic [3:0] CM_BYP15   = 4'h3;

  // Multiplex rate codes {hi, lo}; any other code runs 4:1
  localparam logic [1:0] MUX_8TO1 = 2'b10;
  localparam logic [1:0] MUX_2TO1 = 2'b01;

  // Last phase of a latch group for each rate
  localparam logic [2:0] LAST_8 = 3'h7;
  localparam logic [2:0] LAST_4 = 3'h3;
  localparam logic [2:0] LAST_2 = 3'h1;

  // Pseudo colour source channels
  localparam logic [1:0] CH_RED   = 2'h0;
  localparam logic [1:0] CH_GREEN = 2'h1;
  localparam logic [1:0] CH_BLUE  = 2'h2;

  // Pixel port geometry
  localparam int PIX_W = 8;
  localparam int PORTS = 4;
  localparam int DAC_W = 10;

  typedef enum logic [2:0] {
    MODE_TRUE24,
    MODE_TRUE16,
    MODE_TRUE15A,
    MODE_TRUE15B,
    MODE_PSEUDO,
    MODE_BYP24,
    MODE_BYP16,
    MODE_BYP15
  } pix_mode_e;

endpackage

/* verification/frame_buffer_model.sv */
`timescale 1ns/10ps
module frame_buffer_model (
  // Clock and strobe from the device
  input  wire logic        clk_sys_i,
  input  wire logic        latch_strobe_out_i,
  // Group to present next
  input  wire logic [31:0] next_red_i,
  input  wire logic [31:0] next_green_i,
  input  wire logic [31:0] next_blue_i,
  input  wire logic [7:0]  next_ps_i,
  // Pixel port pins
  output logic             strobe_o,
  output logic      [31:0] red_o,
  output logic      [31:0] green_o,
  output logic      [31:0] blue_o,
  output logic      [7:0]  ps_o
);
  logic strobe_q;
  // Looped straight back, so the strobe is a whole division of the clock
  assign strobe_o = latch_strobe_out_i;
  initial begin
    strobe_q = 1'b0;
    {red_o, green_o, blue_o, ps_o} = '0;
  end
  // Banks shift a new group out only after a strobe rise, like real memory
  always @(posedge clk_sys_i) begin
    strobe_q <= latch_strobe_out_i;
    if (latch_strobe_out_i && !strobe_q) begin
      red_o   <= next_red_i;
      green_o <= next_green_i;
      blue_o  <= next_blue_i;
      ps_o    <= next_ps_i;
    end
  end
endmodule

/* verification/pixel_port_mux_color_mapper_tb.sv */
`timescale 1ns/10ps
module pixel_port_mux_color_mapper_tb;
  logic        clk_sys_i;
  logic        srst_i;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd_s;
  logic [31:0] rdata;
  logic [31:0] nr, ng, nb, r_p, g_p, b_p;
  logic [7:0]  nps, ps_p, mask;
  logic        stb, bl_i, sy_i, oe_i, ts_i, lso, lk, wide, bl_o, sy_o, oe_o, ts_o;
  logic [7:0]  ir, ig, ib;
  logic [9:0]  dr, dg, db;
  logic [1:0]  ps_o;
  logic [56:0] e[8];
  int          bad_count, checked, cycles;

  pixel_port_mux_color_mapper pixel_port_mux_color_mapper_i (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .red_pixel_input_i(r_p),
    .green_pixel_input_i(g_p), .blue_pixel_input_i(b_p), .palette_select_inputs_i(ps_p),
    .pixel_latch_strobe_i(stb), .blank_n_i(bl_i), .sync_n_i(sy_i), .odd_even_i(oe_i),
    .tri_level_sync_i(ts_i), .latch_strobe_out_o(lso), .lut_lookup_o(lk),
    .lut_wide_o(wide), .lut_idx_red_o(ir), .lut_idx_green_o(ig), .lut_idx_blue_o(ib),
    .dac_red_o(dr), .dac_green_o(dg), .dac_blue_o(db), .palette_select_o(ps_o),
    .blank_n_o(bl_o), .sync_n_o(sy_o), .odd_even_o(oe_o), .tri_level_sync_o(ts_o));

  frame_buffer_model frame_buffer_model_i (
    .clk_sys_i(clk_sys_i), .latch_strobe_out_i(lso), .next_red_i(nr), .next_green_i(ng),
    .next_blue_i(nb), .next_ps_i(nps), .strobe_o(stb), .red_o(r_p), .green_o(g_p),
    .blue_o(b_p), .ps_o(ps_p));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // A hung handshake must still reach the verdict
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic check(input string what, input logic [56:0] seen, input logic [56:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= {24'h0, d};
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_sys_i);
    rd_s <= 1'b0;
    @(negedge clk_sys_i);
    d = rdata;
  endtask

  function automatic logic [56:0] obs();
    return {lk, lk ? {ir, ig, ib} : 24'h0, dr, dg, db, ps_o};
  endfunction

  // Expected pixel worked out independently of the design
  function automatic logic [56:0] exp_pix(input logic [3:0] m, input logic [7:0] r, g, b,
                                          input logic [1:0] ps);
    logic [15:0] w;
    logic [14:0] v;
    logic [23:0] ix;
    logic [29:0] dc;
    logic        l;
    w = {r, g};
    v = {r[6:0], g};
    l = 1'b1;
    dc = 30'h0;
    if (ps == 2'h3) m = (m == 4'hb || m == 4'h2) ? 4'h2 :
                        (m[3:1] == 3'h6 || m == 4'h3) ? 4'h3 : 4'h1;
    case (m)
      pixmux_pkg::CM_TRUE24:  ix = {r, g, b};
      pixmux_pkg::CM_TRUE16:  ix = {3'h0, w[15:11], 2'h0, w[10:5], 3'h0, w[4:0]};
      pixmux_pkg::CM_TRUE15A: ix = {3'h0, r[7:3], 3'h0, g[7:3], 3'h0, b[7:3]};
      pixmux_pkg::CM_TRUE15B: ix = {3'h0, v[14:10], 3'h0, v[9:5], 3'h0, v[4:0]};
      pixmux_pkg::CM_PSEUDO4: ix = {3{r & mask}};
      pixmux_pkg::CM_PSEUDO8: ix = {3{b & mask}};
      default:                ix = {3{g & mask}};
    endcase
    l = !(m inside {pixmux_pkg::CM_BYP24, pixmux_pkg::CM_BYP16, pixmux_pkg::CM_BYP15});
    if (m == pixmux_pkg::CM_BYP24) dc = {r, 2'h0, g, 2'h0, b, 2'h0};
    if (m == pixmux_pkg::CM_BYP16) dc = {w[15:11], 5'h0, w[10:5], 4'h0, w[4:0], 5'h0};
    if (m == pixmux_pkg::CM_BYP15) dc = {v[14:10], 5'h0, v[9:5], 5'h0, v[4:0], 5'h0};
    return {l, l ? ix : 24'h0, dc, ps};
  endfunction

  // Finds pixel A in the stream, then expects the whole group and A again
  task automatic stream(input int n);
    int k, i;
    k = -1;
    // New select bits need two strobes and a group swap to reach the output
    repeat (24) @(negedge clk_sys_i);
    for (i = 0; i < 24 && k < 0; i++) begin
      @(negedge clk_sys_i);
      if (obs() === e[0]) k = 0;
    end
    if (k < 0) check("stream start", obs(), e[0]);
    for (i = 1; i <= n; i++) begin
      @(negedge clk_sys_i);
      check("stream pixel", obs(), e[i % n]);
    end
  endtask

  task automatic t_period(input int exp);
    int n, seen;
    logic prev;
    n = 0;
    seen = 0;
    prev = 1'b1;
    repeat (40) begin
      @(negedge clk_sys_i);
      if (lso === 1'b1 && prev === 1'b0) begin
        if (seen == 1) check("strobe period", n, exp);
        seen++;
        n = 0;
      end
      n++;
      prev = lso;
    end
    if (seen < 2) check("strobe edges", 0, 1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [31:0] d;
    rreg(pixmux_pkg::ADDR_STATUS, d);
    check("status after reset", d, 32'h41);
    @(negedge clk_sys_i);
    check("rdata idle", rdata, 0);
    check("wide after reset", wide, 1);
    wreg(4'hc, 8'h00);
    rreg(4'hc, d);
    check("unmapped read", d, 0);
    rreg(pixmux_pkg::ADDR_CTRL, d);
    check("ctrl reset", d, 32'hff);
    wreg(pixmux_pkg::ADDR_MASK, mask);
    rreg(pixmux_pkg::ADDR_MASK, d);
    check("mask readback", d, {24'h0, mask});
  endtask

  task automatic t_modes();
    logic [3:0] cm[12] = '{4'he, 4'hb, 4'hc, 4'hd, 4'h0, 4'h4, 4'h8, 4'h1, 4'h2, 4'h3,
                           4'h5, 4'he};
    logic [2:0] sm[12] = '{0, 1, 2, 3, 4, 4, 4, 5, 6, 7, 4, 0};
    logic [31:0] d;
    for (int i = 0; i < 12; i++) begin
      nps <= (i == 11) ? 8'h0c : 8'h00;
      wreg(pixmux_pkg::ADDR_CTRL, {3'b100, i[0], cm[i]});
      rreg(pixmux_pkg::ADDR_STATUS, d);
      check("status mode", d[6:4], sm[i]);
      check("wide flag", wide, i[0]);
      for (int p = 0; p < 4; p++) begin
        e[p] = exp_pix(cm[i], nr[8*p+:8], ng[8*p+:8], nb[8*p+:8], nps[2*p+:2]);
      end
      stream(4);
    end
    t_period(4);
  endtask

  task automatic t_seq();
    logic [31:0] d;
    wreg(pixmux_pkg::ADDR_CTRL, 8'h80);
    wreg(pixmux_pkg::ADDR_CTRL, 8'h00);
    wreg(pixmux_pkg::ADDR_CTRL, 8'h80);
    rreg(pixmux_pkg::ADDR_STATUS, d);
    check("restart phase", d[2:0], 1);
  endtask

  task automatic t_rates();
    logic [31:0] d;
    wreg(pixmux_pkg::ADDR_CTRL, {3'b101, 1'b0, pixmux_pkg::CM_PSEUDO4});
    e[0] = exp_pix(pixmux_pkg::CM_PSEUDO4, nr[7:0], ng[7:0], nb[7:0], nps[1:0]);
    e[1] = exp_pix(pixmux_pkg::CM_PSEUDO4, nr[15:8], ng[15:8], nb[15:8], nps[3:2]);
    stream(2);
    t_period(2);
    nps <= 8'he4;
    wreg(pixmux_pkg::ADDR_CTRL, {3'b110, 1'b0, pixmux_pkg::CM_TRUE24});
    rreg(pixmux_pkg::ADDR_STATUS, d);
    check("forced pseudo", d[6:4], 4);
    for (int p = 0; p < 4; p++) begin
      // Select bits never bypass the palette at the 8:1 rate
      e[2*p] = exp_pix(4'h0, 0, ng[8*p+:8], 0, 2'h0) | 57'(nps[2*p+:2]);
      e[2*p+1] = exp_pix(4'h0, 0, nr[8*p+:8], 0, 2'h0) | 57'(nb[2*p+:2]);
    end
    stream(8);
    t_period(8);
  endtask

  // Controls toggle mid-group; outputs may only move where pixel A shows
  task automatic t_controls();
    logic [3:0] prev;
    int moves;
    moves = 0;
    wreg(pixmux_pkg::ADDR_CTRL, {3'b100, 1'b0, pixmux_pkg::CM_PSEUDO4});
    for (int p = 0; p < 4; p++) e[p] = exp_pix(4'h4, nr[8*p+:8], 0, 0, nps[2*p+:2]);
    prev = {bl_o, sy_o, oe_o, ts_o};
    for (int i = 0; i < 48; i++) begin
      @(posedge clk_sys_i);
      {bl_i, sy_i, oe_i, ts_i} <= 4'(i / 3);
      @(negedge clk_sys_i);
      if ({bl_o, sy_o, oe_o, ts_o} !== prev) begin
        moves++;
        check("control boundary", obs(), e[0]);
      end
      prev = {bl_o, sy_o, oe_o, ts_o};
    end
    repeat (16) @(negedge clk_sys_i);
    check("control value", {bl_o, sy_o, oe_o, ts_o}, 4'hf);
    check("control moved", moves > 0, 1);
  endtask

  initial begin
    {srst_i, addr, wdata, wr, rd_s} = {1'b1, 38'h0};
    {bl_i, sy_i, oe_i, ts_i} = 4'hc;
    nr = 32'hd4a75c39;
    ng = 32'hf0936b1e;
    nb = 32'hcab54827;
    nps = 8'h00;
    mask = 8'h7e;
    {bad_count, checked, cycles} = 0;
    repeat (8) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    t_reset();
    t_modes();
    t_seq();
    t_rates();
    t_controls();
    end_sim();
  end
endmodule
